// >>> logic/fwp_guard.sv
// Serial flash write-protection front end with array model
// Functional notes
// RULE1: Power-up reset lands in standby, no partial command.
// RULE2: Only complete accepted sequences change memory.
// RULE3: Non-whole-byte frames at deselect are discarded.
// RULE4: Modifying commands need the write latch flag set.
// RULE5: Protected region stays readable, refuses program/erase.
// RULE6: Guard pin low freezes protect and lock bits. The code still lets a two-byte status write change the invert bit.
// RULE7: Deep power-down ignores all but release.
// RULE8: Array starts erased, every byte FFh.
// RULE9: Status starts all zeros.
// RULE10: Host waits 70 us after power before selecting.
// RULE11: 4M plain: low bits zero none, bit2 all.
// RULE12: 4M plain bit4 low: 64K/128K/256K, bit3 side.
// RULE13: 4M plain bit4 high: 4K to 32K or all.
// RULE14: 4M inverted protects exact complement region.
// RULE15: 2M plain bit4 low: none/64K/128K/all.
// RULE16: 2M plain bit4 high: 4K to 32K or all.
// RULE17: 2M inverted protects exact complement region.
// RULE18: Any overlap with protection rejects program/erase.
`timescale 1ns/100ps
module fwp_guard
  import fwp_pkg::*;
#(
  parameter int MEM_AW = 19
) (
  input  wire logic              clk_sys_in,
  input  wire logic              rst_n_in,
  input  wire logic              cs_n_in,
  input  wire logic              sclk_in,
  input  wire logic              mosi_in,
  input  wire logic              write_guard_n_in,
  input  wire logic              dens_2m_in,
  input  wire logic [MEM_AW-1:0] rd_addr_in,
  output logic      [7:0]        rd_data_out,
  output logic      [15:0]       status_out,
  output logic                   write_latch_flag_out,
  output logic                   deep_pd_out,
  output logic                   busy_out,
  output logic                   cmd_done_out,
  output logic                   cmd_ignored_out
);
  fwp_state_e state_q, state_d;

  // Pin synchronisers: {cs_n, sclk, mosi, guard_n}
  logic [3:0] sync1_q, sync2_q;
  logic       cs_s, sclk_s, mosi_s, guard_n_s;
  logic       sclk_d_q;
  logic       sclk_rise;

  logic [2:0]  bit_cnt_q;
  logic [8:0]  byte_cnt_q;
  logic [6:0]  shift_q;
  logic [7:0]  cmd_q;
  logic [23:0] addr_q;
  logic [7:0]  byte_val;
  logic        byte_end;

  logic        latch_q, dpd_q, busy_q, done_q, ign_q;
  logic [4:0]  bp_q;
  logic [1:0]  lock_q;
  logic        inv_q;

  logic [7:0]  mem  [0:(2**MEM_AW)-1];
  logic [7:0]  pbuf [0:255];
  logic [7:0]  rd_q;
  logic [7:0]  pbuf_idx;

  logic [MEM_AW-1:0] eng_ptr_q, eng_ptr_d;
  logic [MEM_AW:0]   eng_left_q, eng_left_d;
  logic              eng_prog_q;
  logic              eng_run;
  logic              eng_last;
  logic [7:0]        eng_wdata;

  assign cs_s      = sync2_q[3];
  assign sclk_s    = sync2_q[2];
  assign mosi_s    = sync2_q[1];
  assign guard_n_s = sync2_q[0];
  assign sclk_rise = sclk_s & ~sclk_d_q;

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync1_q  <= 4'h9;
      sync2_q  <= 4'h9;
      sclk_d_q <= 1'b0;
    end else begin
      sync1_q  <= {cs_n_in, sclk_in, mosi_in, write_guard_n_in};
      sync2_q  <= sync1_q;
      sclk_d_q <= sclk_s;
    end
  end

  // Frame capture: bits are counted so that ragged frames can be dropped
  wire        selected   = (state_q == FWP_SEL);
  wire        cs_release = selected & cs_s;
  assign byte_val = {shift_q, mosi_s};
  assign byte_end = selected & ~cs_s & sclk_rise & (bit_cnt_q == 3'h7);
  assign pbuf_idx = addr_q[7:0] + 8'(byte_cnt_q - FWP_LEN_HDR);

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bit_cnt_q  <= 3'h0;
      byte_cnt_q <= 9'h000;
      shift_q    <= 7'h00;
      cmd_q      <= 8'h00;
      addr_q     <= 24'h000000;
    end else if (state_q == FWP_IDLE) begin
      bit_cnt_q  <= 3'h0;
      byte_cnt_q <= 9'h000;
    end else if (selected && !cs_s && sclk_rise) begin
      bit_cnt_q <= bit_cnt_q + 3'h1;                           // [RULE3]
      shift_q   <= byte_val[6:0];
      if (byte_end) begin
        if (byte_cnt_q != FWP_CNT_MAX) begin
          byte_cnt_q <= byte_cnt_q + 9'h001;
        end
        if (byte_cnt_q == 9'h000) begin
          cmd_q <= byte_val;
        end else if (byte_cnt_q < FWP_LEN_HDR) begin
          addr_q <= {addr_q[15:0], byte_val};
        end
      end
    end
  end

  // Data bytes park in the page buffer; nothing reaches the array before deselect
  always_ff @(posedge clk_sys_in) begin
    if (byte_end && cmd_q == FWP_OP_PROG && byte_cnt_q >= FWP_LEN_HDR) begin
      pbuf[pbuf_idx] <= byte_val;                              // [RULE2]
    end
  end

  // Protection range and target overlap
  logic [19:0] prot_lo, prot_hi;
  logic        prot_none;

  fwp_range_dec u_dec (
    .bp_in      (bp_q),
    .invert_in  (inv_q),
    .dens_2m_in (dens_2m_in),
    .lo_out     (prot_lo),
    .hi_out     (prot_hi),
    .none_out   (prot_none)
  );

  wire [19:0] full   = dens_2m_in ? FWP_FULL_2M : FWP_FULL_4M;
  wire [19:0] addr_m = {1'b0, addr_q[18] & ~dens_2m_in, addr_q[17:0]};
  wire [19:0] tgt_mask = (cmd_q == FWP_OP_PROG)     ? FWP_PAGE_LOW :
                         (cmd_q == FWP_OP_ERASE_4K) ? FWP_SECT_LOW : FWP_BLK_LOW;
  wire        is_all = (cmd_q == FWP_OP_ERASE_ALL);
  wire [19:0] tgt_lo = is_all ? 20'h00000 : (addr_m & ~tgt_mask);
  wire [19:0] tgt_hi = is_all ? full - 20'h00001 : (addr_m | tgt_mask);
  wire        hit    = ~prot_none & (tgt_lo <= prot_hi) & (tgt_hi >= prot_lo);  // [RULE18] [RULE5]

  // Command acceptance at deselect
  wire whole     = cs_release & (bit_cnt_q == 3'h0) & (byte_cnt_q != 9'h000);  // [RULE3]
  wire short_cmd = whole & (byte_cnt_q == FWP_LEN_CMD);
  wire awake     = whole & ~dpd_q;                             // [RULE7]
  wire op_wake   = short_cmd & (cmd_q == FWP_OP_WAKE);
  wire op_unlock = awake & short_cmd & (cmd_q == FWP_OP_UNLOCK);
  wire op_relock = awake & short_cmd & (cmd_q == FWP_OP_RELOCK);
  wire op_sleep  = awake & short_cmd & (cmd_q == FWP_OP_SLEEP);
  wire op_srw    = awake & latch_q & (cmd_q == FWP_OP_STATUS_WR) &
                   ((byte_cnt_q == FWP_LEN_SR1) | (byte_cnt_q == FWP_LEN_SR2));  // [RULE4]
  wire op_prog   = awake & latch_q & (cmd_q == FWP_OP_PROG) & (byte_cnt_q > FWP_LEN_HDR);
  wire op_erase  = awake & latch_q &
                   ((((cmd_q == FWP_OP_ERASE_4K) | (cmd_q == FWP_OP_ERASE_64K)) & (byte_cnt_q == FWP_LEN_ERASE)) |
                    (is_all & (byte_cnt_q == FWP_LEN_CMD)));   // [RULE4]
  wire start_eng = (op_prog | op_erase) & ~hit;                // [RULE5] [RULE18]
  wire accepted  = op_wake | op_unlock | op_relock | op_sleep | op_srw | start_eng;

  // Status write: guard pin low holds block-protect and lock bits; the invert bit is still written
  wire       sr_two  = (byte_cnt_q == FWP_LEN_SR2);
  wire [7:0] sr_low  = sr_two ? addr_q[15:8] : addr_q[7:0];
  wire [7:0] sr_high = addr_q[7:0];
  wire       frozen  = ~guard_n_s;

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      latch_q <= FWP_STATUS_RST[FWP_SB_LATCH];                 // [RULE9]
      bp_q   <= FWP_STATUS_RST[FWP_SB_BP +: 5];
      lock_q <= {FWP_STATUS_RST[FWP_SB_LOCK1], FWP_STATUS_RST[FWP_SB_LOCK0]};
      inv_q  <= FWP_STATUS_RST[FWP_SB_INV];
      dpd_q  <= 1'b0;
    end else begin
      if (op_unlock) begin
        latch_q <= 1'b1;                                       // [RULE4]
      end else if (op_relock || op_srw || op_prog || op_erase) begin
        latch_q <= 1'b0;
      end
      if (op_srw && !frozen) begin
        bp_q      <= sr_low[FWP_SB_BP +: 5];                   // [RULE6]
        lock_q[0] <= sr_low[FWP_SB_LOCK0];
        if (sr_two) begin
          lock_q[1] <= sr_high[FWP_SB_LOCK1 - 8];
        end
      end
      if (op_srw && sr_two) begin
        inv_q <= sr_high[FWP_SB_INV - 8];
      end
      if (op_sleep) begin
        dpd_q <= 1'b1;                                         // [RULE7]
      end else if (op_wake) begin
        dpd_q <= 1'b0;
      end
    end
  end

  // Write engine: power-up fill, erase sweep and page commit share one port
  wire [8:0] n_data   = byte_cnt_q - FWP_LEN_HDR;
  wire [8:0] prog_len = (n_data > FWP_PAGE_LEN) ? FWP_PAGE_LEN : n_data;
  assign eng_run   = (state_q == FWP_INIT) | (state_q == FWP_WORK);
  assign eng_last  = (eng_left_q == '0);
  assign eng_wdata = eng_prog_q ? pbuf[eng_ptr_q[7:0]] : FWP_ERASED;

  always_comb begin
    eng_ptr_d  = eng_ptr_q;
    eng_left_d = eng_left_q;
    if (start_eng) begin
      if (op_prog) begin
        eng_ptr_d  = MEM_AW'(addr_m);
        eng_left_d = (MEM_AW+1)'(prog_len - 9'h001);
      end else begin
        eng_ptr_d  = MEM_AW'(tgt_lo);
        eng_left_d = (MEM_AW+1)'(tgt_hi - tgt_lo);
      end
    end else if (eng_run && !eng_last) begin
      eng_left_d = eng_left_q - 1'b1;
      // Page program wraps within its page
      eng_ptr_d  = eng_prog_q ? {eng_ptr_q[MEM_AW-1:8], eng_ptr_q[7:0] + 8'h01} : eng_ptr_q + 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      eng_ptr_q  <= '0;
      eng_left_q <= (MEM_AW+1)'((2**MEM_AW) - 1);              // [RULE8]
      eng_prog_q <= 1'b0;
    end else begin
      eng_ptr_q  <= eng_ptr_d;
      eng_left_q <= eng_left_d;
      if (start_eng) begin
        eng_prog_q <= op_prog;
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (eng_run) begin
      mem[eng_ptr_q] <= eng_wdata;                             // [RULE8] [RULE2]
    end
    rd_q <= mem[rd_addr_in];                                   // [RULE5]
  end

  // Command sequencer
  always_comb begin
    state_d = state_q;
    case (state_q)
      FWP_INIT: begin
        if (eng_last) state_d = FWP_STBY;
      end
      FWP_STBY: begin
        if (cs_s) state_d = FWP_IDLE;                          // [RULE1]
      end
      FWP_IDLE: begin
        if (!cs_s) state_d = FWP_SEL;
      end
      FWP_SEL: begin
        if (cs_s) state_d = start_eng ? FWP_WORK : FWP_IDLE;
      end
      FWP_WORK: begin
        if (eng_last) state_d = FWP_STBY;
      end
      default: state_d = FWP_STBY;
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q <= FWP_INIT;                                     // [RULE1]
      busy_q  <= 1'b1;
      done_q  <= 1'b0;
      ign_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      busy_q  <= (state_d == FWP_INIT) | (state_d == FWP_WORK);
      done_q  <= accepted;
      ign_q   <= cs_release & ~accepted;
    end
  end

  assign rd_data_out          = rd_q;
  assign write_latch_flag_out = latch_q;
  assign deep_pd_out          = dpd_q;
  assign busy_out             = busy_q;
  assign cmd_done_out         = done_q;
  assign cmd_ignored_out      = ign_q;

  always_comb begin
    status_out                = FWP_STATUS_RST;
    status_out[FWP_SB_BUSY]   = busy_q;
    status_out[FWP_SB_LATCH]  = latch_q;
    status_out[FWP_SB_BP +: 5] = bp_q;
    status_out[FWP_SB_LOCK0]  = lock_q[0];
    status_out[FWP_SB_LOCK1]  = lock_q[1];
    status_out[FWP_SB_INV]    = inv_q;
  end
endmodule : fwp_guard

// >>> logic/fwp_pkg.sv
// Shared constants and types of the flash write-protection block
package fwp_pkg;
  // Command opcodes
  localparam logic [7:0] FWP_OP_UNLOCK    = 8'h06;
  localparam logic [7:0] FWP_OP_RELOCK    = 8'h04;
  localparam logic [7:0] FWP_OP_STATUS_WR = 8'h01;
  localparam logic [7:0] FWP_OP_PROG      = 8'h02;
  localparam logic [7:0] FWP_OP_ERASE_4K  = 8'h20;
  localparam logic [7:0] FWP_OP_ERASE_64K = 8'hD8;
  localparam logic [7:0] FWP_OP_ERASE_ALL = 8'hC7;
  localparam logic [7:0] FWP_OP_SLEEP     = 8'hB9;
  localparam logic [7:0] FWP_OP_WAKE      = 8'hAB;

  // Region sizes in bytes, 20-bit byte address space
  localparam logic [19:0] FWP_FULL_4M = 20'h80000;
  localparam logic [19:0] FWP_FULL_2M = 20'h40000;
  localparam logic [19:0] FWP_SZ_4K   = 20'h01000;
  localparam logic [19:0] FWP_SZ_8K   = 20'h02000;
  localparam logic [19:0] FWP_SZ_16K  = 20'h04000;
  localparam logic [19:0] FWP_SZ_32K  = 20'h08000;
  localparam logic [19:0] FWP_SZ_64K  = 20'h10000;
  localparam logic [19:0] FWP_SZ_128K = 20'h20000;
  localparam logic [19:0] FWP_SZ_256K = 20'h40000;
  localparam logic [19:0] FWP_SECT_LOW = 20'h00FFF;
  localparam logic [19:0] FWP_BLK_LOW  = 20'h0FFFF;
  localparam logic [19:0] FWP_PAGE_LOW = 20'h000FF;

  // Values after reset
  localparam logic [7:0]  FWP_ERASED     = 8'hFF;
  localparam logic [15:0] FWP_STATUS_RST = 16'h0000;

  // Status word layout
  localparam int FWP_SB_BUSY  = 0;
  localparam int FWP_SB_LATCH = 1;
  localparam int FWP_SB_BP    = 2;
  localparam int FWP_SB_LOCK0 = 7;
  localparam int FWP_SB_LOCK1 = 8;
  localparam int FWP_SB_INV   = 14;

  // Frame lengths in bytes
  localparam logic [8:0] FWP_LEN_CMD   = 9'h001;
  localparam logic [8:0] FWP_LEN_SR1   = 9'h002;
  localparam logic [8:0] FWP_LEN_SR2   = 9'h003;
  localparam logic [8:0] FWP_LEN_ERASE = 9'h004;
  localparam logic [8:0] FWP_LEN_HDR   = 9'h004;
  localparam logic [8:0] FWP_PAGE_LEN  = 9'h100;
  localparam logic [8:0] FWP_CNT_MAX   = 9'h1FF;

  typedef enum logic [2:0] {FWP_INIT, FWP_STBY, FWP_IDLE, FWP_SEL, FWP_WORK} fwp_state_e;
endpackage : fwp_pkg

// >>> logic/fwp_range_dec.sv
// Block-protect decoder: protect bits to protected byte range
`timescale 1ns/100ps
module fwp_range_dec
  import fwp_pkg::*;
(
  input  wire logic [4:0]  bp_in,
  input  wire logic        invert_in,
  input  wire logic        dens_2m_in,
  output logic      [19:0] lo_out,
  output logic      [19:0] hi_out,
  output logic             none_out
);
  logic [19:0] full;
  logic [19:0] size;
  logic        bottom;

  assign full = dens_2m_in ? FWP_FULL_2M : FWP_FULL_4M;

  always_comb begin
    size   = 20'h00000;
    bottom = bp_in[3];                                         // [RULE12] [RULE13] [RULE15] [RULE16]
    if (!bp_in[4]) begin
      if (!dens_2m_in && bp_in[2]) begin
        size = full;                                           // [RULE11]
      end else begin
        case (bp_in[1:0])
          2'b01:   size = FWP_SZ_64K;                          // [RULE12] [RULE15]
          2'b10:   size = FWP_SZ_128K;
          2'b11:   size = dens_2m_in ? full : FWP_SZ_256K;
          default: size = 20'h00000;                           // [RULE11]
        endcase
      end
    end else begin
      case (bp_in[2:0])
        3'b001:  size = FWP_SZ_4K;                             // [RULE13] [RULE16]
        3'b010:  size = FWP_SZ_8K;
        3'b011:  size = FWP_SZ_16K;
        3'b100,
        3'b101,
        3'b110:  size = FWP_SZ_32K;
        3'b111:  size = full;
        default: size = 20'h00000;
      endcase
    end
    // Complement side: none and all swap, partial regions flip to the other end
    if (invert_in) begin
      if (size == 20'h00000) begin
        size = full;                                           // [RULE14] [RULE17]
      end else if (size == full) begin
        size = 20'h00000;
      end else begin
        size   = full - size;
        bottom = ~bottom;
      end
    end
  end

  assign none_out = (size == 20'h00000);
  assign lo_out   = bottom ? 20'h00000 : full - size;
  assign hi_out   = bottom ? size - 20'h00001 : full - 20'h00001;
endmodule : fwp_range_dec

// >>> bench/fwp_guard_monitor.sv
// Concurrent checks on the ports of the write-protection block
`timescale 1ns/100ps
module fwp_guard_monitor #(
  parameter int MEM_AW = 19
) (
  input wire logic              clk_sys_in,
  input wire logic              rst_n_in,
  input wire logic              cs_n_in,
  input wire logic              sclk_in,
  input wire logic              mosi_in,
  input wire logic              write_guard_n_in,
  input wire logic              dens_2m_in,
  input wire logic [MEM_AW-1:0] rd_addr_in,
  input wire logic [7:0]        rd_data_out,
  input wire logic [15:0]       status_out,
  input wire logic              write_latch_flag_out,
  input wire logic              deep_pd_out,
  input wire logic              busy_out,
  input wire logic              cmd_done_out,
  input wire logic              cmd_ignored_out
);
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_n_in);

  property p_done_deselect;
    cmd_done_out |-> $past(cs_n_in, 2) ##1 !cmd_done_out;
  endproperty
  a_done_deselect: assert property (p_done_deselect) else $error("action while selected");
  property p_ign_deselect;
    cmd_ignored_out |-> $past(cs_n_in, 2) && !cmd_done_out ##1 !cmd_ignored_out;
  endproperty
  a_ign_deselect: assert property (p_ign_deselect) else $error("bad ignore pulse");
  property p_latch_by_cmd;
    $rose(write_latch_flag_out) |-> cmd_done_out && !deep_pd_out;
  endproperty
  a_latch_by_cmd: assert property (p_latch_by_cmd) else $error("latch set without command");
  property p_sweep_latch;
    $rose(busy_out) |-> $past(write_latch_flag_out) && !write_latch_flag_out && cmd_done_out;
  endproperty
  a_sweep_latch: assert property (p_sweep_latch) else $error("array change without latch");
  property p_guard_freeze;
    (!write_guard_n_in) [*5] |-> $stable(status_out[8:2]);
  endproperty
  a_guard_freeze: assert property (p_guard_freeze) else $error("protect bits moved while guarded");
  property p_sleep_hold;
    $past(deep_pd_out) && deep_pd_out |-> $stable(status_out);
  endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("status moved in power-down");
  property p_sleep_release;
    $past(deep_pd_out) && cmd_done_out |-> !deep_pd_out;
  endproperty
  a_sleep_release: assert property (p_sleep_release) else $error("command acted in power-down");
  property p_status_by_cmd;
    !$stable(status_out[14:2]) |-> cmd_done_out;
  endproperty
  a_status_by_cmd: assert property (p_status_by_cmd) else $error("status changed without command");
  property p_busy_quiet;
    $past(busy_out) && busy_out |-> !cmd_done_out && !cmd_ignored_out;
  endproperty
  a_busy_quiet: assert property (p_busy_quiet) else $error("frame taken while busy");
endmodule : fwp_guard_monitor

bind fwp_guard fwp_guard_monitor #(.MEM_AW(MEM_AW)) u_fwp_guard_monitor (
  .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .cs_n_in(cs_n_in), .sclk_in(sclk_in),
  .mosi_in(mosi_in), .write_guard_n_in(write_guard_n_in), .dens_2m_in(dens_2m_in),
  .rd_addr_in(rd_addr_in), .rd_data_out(rd_data_out), .status_out(status_out),
  .write_latch_flag_out(write_latch_flag_out), .deep_pd_out(deep_pd_out), .busy_out(busy_out),
  .cmd_done_out(cmd_done_out), .cmd_ignored_out(cmd_ignored_out));

// >>> bench/fwp_host_model.sv
// SPI host model driving select, clock and data into the guard block
`timescale 1ns/100ps
module fwp_host_model (
  output logic cs_n_out,
  output logic sclk_out,
  output logic mosi_out
);
  initial begin
    cs_n_out = 1'b1;
    sclk_out = 1'b0;
    mosi_out = 1'b0;
  end

  // Mode 0 frame, bits left-aligned in dat; clock stands still between frames
  task automatic frame(input logic [47:0] dat, input int nbits);
    cs_n_out = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      mosi_out = dat[47-i];
      #200 sclk_out = 1'b1;
      #200 sclk_out = 1'b0;
    end
    #200 cs_n_out = 1'b1;
    // Released line flips so a stale bit is never read as data
    mosi_out = ~mosi_out;
  endtask : frame
endmodule : fwp_host_model

// >>> bench/tb.sv
// Self-checking bench for the flash write-protection block
`timescale 1ns/100ps
module tb;
  import fwp_pkg::*;
  logic        clk_sys_in, rst_n_in, cs_n, sclk, mosi, wg_n, dens;
  logic [11:0] rd_addr;
  logic [7:0]  rd_data;
  logic [15:0] status;
  logic        latch, dpd, busy, done, ign, got_done, got_ign;
  int          bad_count = 0;
  int          total_checks = 0;
  logic [27:0] cases [21] = '{28'h0000000, 28'h0900000, 28'h130FFFF, 28'h1210000, 28'h0740000,
    28'h063FFFF, 28'h237F000, 28'h227EFFF, 28'h3B07FFF, 28'h3A08000, 28'h436FFFF, 28'h4270000,
    28'h4100000, 28'h8700000, 28'h8B30000, 28'h8A2FFFF, 28'hA53E000, 28'hA43DFFF, 28'hC32FFFF,
    28'hC230000, 28'hC600000};

  fwp_host_model u_fwp_host_model (.cs_n_out(cs_n), .sclk_out(sclk), .mosi_out(mosi));
  fwp_guard #(.MEM_AW(12)) u_fwp_guard (
    .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .cs_n_in(cs_n), .sclk_in(sclk), .mosi_in(mosi),
    .write_guard_n_in(wg_n), .dens_2m_in(dens), .rd_addr_in(rd_addr), .rd_data_out(rd_data),
    .status_out(status), .write_latch_flag_out(latch), .deep_pd_out(dpd), .busy_out(busy),
    .cmd_done_out(done), .cmd_ignored_out(ign));

  initial begin
    clk_sys_in = 1'b0;
    forever #25 clk_sys_in = ~clk_sys_in;
  end

  task automatic chk_word(input string nm, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_word

  task automatic chk_bit(input string nm, input logic e, input logic g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_bit

  task automatic wait_idle();
    for (int i = 0; i < 5000 && busy !== 1'b0; i++) @(negedge clk_sys_in);
    chk_bit("busy cleared", 1'b0, busy);
  endtask : wait_idle

  // Sends a frame, catches the one-cycle answer pulse, then lets any sweep finish
  task automatic send(input logic [47:0] dat, input int nbits);
    got_done = 1'b0;
    got_ign = 1'b0;
    u_fwp_host_model.frame(dat, nbits);
    for (int i = 0; i < 12 && !(got_done || got_ign); i++) begin
      @(negedge clk_sys_in);
      got_done = done;
      got_ign = ign;
    end
    chk_bit("answer pulse", 1'b1, got_done | got_ign);
    repeat (4) @(negedge clk_sys_in);
    wait_idle();
  endtask : send

  task automatic unlock();
    send({FWP_OP_UNLOCK, 40'h0}, 8);
  endtask : unlock

  task automatic wr_status(input logic [4:0] bp, input logic inv);
    send({FWP_OP_STATUS_WR, 1'b0, bp, 2'b00, 1'b0, inv, 6'h00, 24'h0}, 24);
  endtask : wr_status

  task automatic rd(input logic [11:0] a);
    @(negedge clk_sys_in) rd_addr = a;
    @(negedge clk_sys_in);
  endtask : rd

  task automatic t_power();
    chk_word("status after power-up", FWP_STATUS_RST, status);
    for (int k = 0; k < 4096; k += 1365) begin
      rd(k[11:0]);
      chk_word("erased byte", {8'h00, FWP_ERASED}, {8'h00, rd_data});
    end
    $display("test power done");
  endtask : t_power

  task automatic t_latch();
    send({FWP_OP_PROG, 24'h000020, 8'h11, 8'h00}, 40);
    chk_bit("program without latch ignored", 1'b1, got_ign);
    rd(12'h020);
    chk_word("byte kept", 16'h00FF, {8'h00, rd_data});
    unlock();
    chk_bit("unlock acted", 1'b1, got_done);
    chk_bit("latch flag", 1'b1, latch);
    send({FWP_OP_STATUS_WR, 8'h7C, 32'h0}, 15);
    chk_bit("ragged status write ignored", 1'b1, got_ign);
    chk_word("status after ragged", 16'h0002, status);
    send({FWP_OP_RELOCK, 40'h0}, 8);
    chk_bit("relock clears latch", 1'b0, latch);
    send({FWP_OP_UNLOCK, 40'h0}, 7);
    chk_bit("ragged unlock ignored", 1'b1, got_ign);
    chk_bit("latch stays clear", 1'b0, latch);
    $display("test latch done");
  endtask : t_latch

  task automatic t_prot();
    logic       inv, pr;
    logic [4:0] bp;
    logic [19:0] a;
    logic [7:0]  d;
    foreach (cases[i]) begin
      {dens, inv, bp, pr, a} = cases[i];
      // A fresh data byte per case, so a skipped write cannot pass on an earlier value
      d = 8'h30 + 8'(i);
      unlock();
      wr_status(bp, inv);
      chk_word("status protect field", {1'b0, inv, 7'h00, bp, 2'b00}, status);
      unlock();
      send({FWP_OP_PROG, 4'h0, a, d, 8'h00}, 40);
      chk_bit("refused", pr, got_ign);
      if (pr == 1'b0) begin
        rd(a[11:0]);
        chk_word("programmed byte", {8'h00, d}, {8'h00, rd_data});
      end
    end
    dens = 1'b0;
    $display("test protect done");
  endtask : t_prot

  task automatic t_guard();
    unlock();
    wr_status(5'h00, 1'b0);
    wg_n = 1'b0;
    unlock();
    send({FWP_OP_STATUS_WR, 8'hFC, 8'h41, 24'h0}, 24);
    chk_word("guarded status", 16'h4000, status);
    @(negedge clk_sys_in) wg_n = 1'b1;
    repeat (4) @(negedge clk_sys_in);
    unlock();
    send({FWP_OP_STATUS_WR, 8'hFC, 8'h41, 24'h0}, 24);
    chk_word("unguarded status", 16'h41FC, status);
    unlock();
    wr_status(5'h00, 1'b0);
    $display("test guard done");
  endtask : t_guard

  task automatic t_sleep();
    send({FWP_OP_SLEEP, 40'h0}, 8);
    chk_bit("power-down entered", 1'b1, dpd);
    unlock();
    chk_bit("unlock ignored asleep", 1'b1, got_ign);
    chk_bit("latch still clear", 1'b0, latch);
    send({FWP_OP_WAKE, 40'h0}, 8);
    chk_bit("release acted", 1'b1, got_done);
    chk_bit("power-down left", 1'b0, dpd);
    $display("test sleep done");
  endtask : t_sleep

  // Top 64K protected: chip and block erase over it refused, sector erase at the bottom acts
  task automatic t_erase();
    unlock();
    wr_status(5'h01, 1'b0);
    unlock();
    send({FWP_OP_ERASE_ALL, 40'h0}, 8);
    chk_bit("chip erase refused", 1'b1, got_ign);
    chk_bit("latch cleared on refusal", 1'b0, latch);
    unlock();
    send({FWP_OP_ERASE_64K, 24'h070000, 16'h0}, 32);
    chk_bit("block erase refused", 1'b1, got_ign);
    unlock();
    send({FWP_OP_ERASE_4K, 24'h000000, 16'h0}, 32);
    chk_bit("sector erase acted", 1'b1, got_done);
    for (int k = 0; k < 4096; k += 4095) begin
      rd(k[11:0]);
      chk_word("byte after erase", 16'h00FF, {8'h00, rd_data});
    end
    $display("test erase done");
  endtask : t_erase

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : close_out

  initial begin
    rst_n_in = 1'b0;
    wg_n = 1'b1;
    dens = 1'b0;
    rd_addr = 12'h000;
    repeat (2) @(negedge clk_sys_in);
    chk_bit("busy in reset", 1'b1, busy);
    rst_n_in = 1'b1;
    // Host stays deselected through the fill, well past the power-up wait
    wait_idle();
    repeat (4) @(negedge clk_sys_in);
    t_power();
    t_latch();
    t_prot();
    t_guard();
    t_erase();
    t_sleep();
    close_out();
  end

  initial begin
    repeat (80000) @(posedge clk_sys_in);
    bad_count++;
    close_out();
  end
endmodule : tb
